//--- cfl_pkg.sv
package cfl_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CFG_CLK_PERIOD_NS = 160;
   localparam int CFG_HALF_CYC = CFG_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [3:0] DIV_LAST = 4'(CFG_HALF_CYC - 1);
   localparam logic [2:0] BIT_LAST = 3'h7;

   // ----------------------------------------
   // Mode and variant codes
   // ----------------------------------------
   localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
   localparam logic [2:0] MODE_SERIAL_FLASH = 3'h1;
   localparam logic [2:0] MODE_PARALLEL_FLASH = 3'h2;
   localparam logic [2:0] VAR_FAST = 3'h7;
   localparam logic [2:0] VAR_READ = 3'h5;
   localparam logic [2:0] VAR_ARRAY = 3'h6;
   localparam logic [7:0] CMD_FAST_READ = 8'h0B;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hE8;
   localparam logic [7:0] FILL_BYTE = 8'h00;

   // ----------------------------------------
   // Counts
   // ----------------------------------------
   localparam int LEN_W = 24;
   localparam logic [LEN_W-1:0] CNT_ONE = 24'h1;
   localparam logic [LEN_W-1:0] ADDR_LAST = 24'h2;
   localparam logic [LEN_W-1:0] DUMMY_FAST = 24'h1;
   localparam logic [LEN_W-1:0] DUMMY_READ = 24'h0;
   localparam logic [LEN_W-1:0] DUMMY_ARRAY = 24'h4;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int AW = 12;
   localparam logic [AW-1:0] REG_CTRL = 12'h000;
   localparam logic [AW-1:0] REG_LEN = 12'h004;
   localparam logic [AW-1:0] REG_STATUS = 12'h008;
   localparam logic [AW-1:0] REG_COUNT = 12'h00C;
   localparam int CTRL_DAISY_BIT = 0;
   localparam int CTRL_EXT_DONE_BIT = 1;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_ERR_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_MODE_LSB = 4;
   localparam int ST_VAR_LSB = 8;
   localparam int ST_PUD_BIT = 12;
   localparam int ST_CLKIN_BIT = 13;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic pullup_disable_strap;
      logic [2:0] mode;
      logic [2:0] flash_variant_straps;
   } cfl_straps_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_DECIDE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_FIN, ST_EXT, ST_ERR
   } cfl_state_t;
endpackage

//--- cfl_shifter.sv
// Byte shifter, clock idle low, mosi moves on falling edge, miso taken on rising
module cfl_shifter (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Byte request
   input wire logic i_start,
   input wire logic [7:0] i_tx_byte,
   input wire logic i_miso,
   // Serial side and result
   output logic o_sclk,
   output logic o_mosi,
   output logic [7:0] o_rx_byte,
   output logic o_busy,
   output logic o_done
);
   import cfl_pkg::*;

   logic [3:0] div_r;
   logic [2:0] bit_r;
   logic [7:0] tx_r;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         div_r <= 4'h0;
         bit_r <= 3'h0;
         tx_r <= 8'h00;
         o_sclk <= 1'h0;
         o_mosi <= 1'h0;
         o_rx_byte <= 8'h00;
         o_busy <= 1'h0;
         o_done <= 1'h0;
      end else begin
         o_done <= 1'h0;
         if (!o_busy && i_start) begin
            o_busy <= 1'h1;
            tx_r <= i_tx_byte;
            o_mosi <= i_tx_byte[7];
            bit_r <= 3'h0;
            div_r <= 4'h0;
            o_sclk <= 1'h0;
         end else if (o_busy) begin
            if (div_r == DIV_LAST) begin
               div_r <= 4'h0;
               o_sclk <= ~o_sclk;
               if (!o_sclk) begin
                  o_rx_byte <= {o_rx_byte[6:0], i_miso};
               end else if (bit_r == BIT_LAST) begin
                  o_busy <= 1'h0;
                  o_done <= 1'h1;
               end else begin
                  bit_r <= bit_r + 3'h1;
                  tx_r <= {tx_r[6:0], 1'h0};
                  o_mosi <= tx_r[6];
               end
            end else begin
               div_r <= div_r + 4'h1;
            end
         end
      end
   end
endmodule // cfl_shifter

//--- cfl_loader.sv
// How it works
// R1: Mode and variant straps are caught when init pin rises.
// R2: Variant code matters only in serial-flash mode.
// R3: Variant 111 sends command 0x0B and one dummy byte.
// R4: Variant 101 sends command 0x03 and no dummy byte.
// R5: Variant 110 sends command 0xE8 and four dummy bytes.
// R6: Pull-up strap low keeps user pull-ups on until done.
// R7: Pull-up strap high turns pull-ups off, user pins float.
// R8: Board presents stable strap levels when configuration starts.
// R9: Board keeps the pull-up strap constant through configuration.
// R10: Dual-purpose pins released only once done is high.
// R11: Master serial, serial and parallel flash modes drive config clock.
// R12: Parallel flash mode clocks config pin only for daisy chain.
// R13: Other variant codes are reserved; no flash read is made.
// R14: Command, zero 24-bit address, dummies, then data MSB first.
module cfl_loader (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [cfl_pkg::AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Straps and init pin
   input wire cfl_pkg::cfl_straps_t i_straps,
   input wire logic i_init_n,
   // Config clock pin
   input wire logic i_config_clock_pin,
   output logic o_config_clock_pin,
   output logic o_config_clock_pin_oe,
   // Serial flash
   output logic o_flash_cs_n,
   output logic o_flash_mosi,
   input wire logic i_flash_miso,
   // Loaded data
   output logic [7:0] o_cfg_byte,
   output logic o_cfg_byte_valid,
   // User pin control
   output logic o_user_pullup_en,
   output logic o_user_pins_hiz,
   output logic o_dual_pins_release,
   output logic o_done
);
   import cfl_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cfl_straps_t straps_s1, straps_s2, cap_r;
   cfl_state_t state_r;
   logic init_s1, init_s2, init_s3, init_rise;
   logic miso_s1, miso_s2, config_clock_pin_s1, config_clock_pin_s2;
   logic daisy_r, ext_done_r, done_r, acc, hit;
   logic [LEN_W-1:0] len_r, cnt_r, cnt_nxt, dummy_n;
   logic [31:0] rd_data;
   logic [7:0] cmd, sh_tx, sh_rx;
   logic var_ok, sh_start, sh_busy, sh_done, sh_sclk, sh_mosi;
   logic shifting, drive_clk;
   logic [3:0] bdiv_r;
   logic bclk_r;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Straps and pins are asynchronous, two flops before any use
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         straps_s1 <= '0;
         straps_s2 <= '0;
         init_s1 <= 1'h0;
         init_s2 <= 1'h0;
         init_s3 <= 1'h0;
         miso_s1 <= 1'h0;
         miso_s2 <= 1'h0;
         config_clock_pin_s1 <= 1'h0;
         config_clock_pin_s2 <= 1'h0;
      end else begin
         straps_s1 <= i_straps;
         straps_s2 <= straps_s1;
         init_s1 <= i_init_n;
         init_s2 <= init_s1;
         init_s3 <= init_s2;
         miso_s1 <= i_flash_miso;
         miso_s2 <= miso_s1;
         config_clock_pin_s1 <= i_config_clock_pin;
         config_clock_pin_s2 <= config_clock_pin_s1;
      end
   end

   assign init_rise = init_s2 & ~init_s3;

   // ----------------------------------------
   // Variant decode
   // ----------------------------------------
   always_comb begin
      cmd = FILL_BYTE;
      dummy_n = DUMMY_READ;
      var_ok = 1'h1;
      unique case (cap_r.flash_variant_straps)
         // R3: fast read
         VAR_FAST: begin
            cmd = CMD_FAST_READ;
            dummy_n = DUMMY_FAST;
         end
         // R4: plain read
         VAR_READ: begin
            cmd = CMD_READ;
            dummy_n = DUMMY_READ;
         end
         // R5: read array
         VAR_ARRAY: begin
            cmd = CMD_READ_ARRAY;
            dummy_n = DUMMY_ARRAY;
         end
         // R13: reserved code
         default: begin
            var_ok = 1'h0;
         end
      endcase
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   assign shifting = (state_r == ST_CMD) || (state_r == ST_ADDR) || (state_r == ST_DUMMY)
      || ((state_r == ST_DATA) && (len_r != '0));
   // Hold off a cycle after done so the next byte sees the new state
   assign sh_start = shifting && !sh_busy && !sh_done;
   // R14: command first, then zero address and fill
   assign sh_tx = (state_r == ST_CMD) ? cmd : FILL_BYTE;
   assign cnt_nxt = cnt_r + CNT_ONE;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         cap_r <= '0;
         cnt_r <= '0;
         done_r <= 1'h0;
         o_flash_cs_n <= 1'h1;
         o_cfg_byte <= 8'h00;
         o_cfg_byte_valid <= 1'h0;
      end else begin
         o_cfg_byte_valid <= 1'h0;
         unique case (state_r)
            ST_IDLE: begin
               // R1: catch straps on init rising
               if (init_rise) begin
                  cap_r <= straps_s2;
                  state_r <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin
               cnt_r <= '0;
               // R2: variant only used in serial flash mode
               if (cap_r.mode == MODE_SERIAL_FLASH) begin
                  if (var_ok) begin
                     o_flash_cs_n <= 1'h0;
                     state_r <= ST_CMD;
                  end else begin
                     state_r <= ST_ERR;
                  end
               end else if (cap_r.mode == MODE_MASTER_SERIAL) begin
                  state_r <= ST_DATA;
               end else begin
                  state_r <= ST_EXT;
               end
            end
            ST_CMD: begin
               if (sh_done) begin
                  state_r <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               // R14: three zero address bytes
               if (sh_done) begin
                  if (cnt_r == ADDR_LAST) begin
                     cnt_r <= '0;
                     state_r <= (dummy_n == '0) ? ST_DATA : ST_DUMMY;
                  end else begin
                     cnt_r <= cnt_nxt;
                  end
               end
            end
            ST_DUMMY: begin
               // R3: dummy byte count from variant
               if (sh_done) begin
                  if (cnt_nxt == dummy_n) begin
                     cnt_r <= '0;
                     state_r <= ST_DATA;
                  end else begin
                     cnt_r <= cnt_nxt;
                  end
               end
            end
            ST_DATA: begin
               // R14: data streamed, MSB first
               if (len_r == '0) begin
                  state_r <= ST_FIN;
               end else if (sh_done) begin
                  o_cfg_byte <= sh_rx;
                  o_cfg_byte_valid <= 1'h1;
                  cnt_r <= cnt_nxt;
                  if (cnt_nxt == len_r) begin
                     state_r <= ST_FIN;
                  end
               end
            end
            ST_EXT: begin
               if (ext_done_r) begin
                  state_r <= ST_FIN;
               end
            end
            ST_FIN: begin
               o_flash_cs_n <= 1'h1;
               done_r <= 1'h1;
            end
            // R13: reserved variant stops here, flash untouched
            ST_ERR: begin
               o_flash_cs_n <= 1'h1;
            end
         endcase
      end
   end

   cfl_shifter cfl_shifter_inst (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_start(sh_start),
      .i_tx_byte(sh_tx),
      .i_miso(miso_s2),
      .o_sclk(sh_sclk),
      .o_mosi(sh_mosi),
      .o_rx_byte(sh_rx),
      .o_busy(sh_busy),
      .o_done(sh_done)
   );

   // ----------------------------------------
   // Config clock and pins
   // ----------------------------------------
   // R11: this end drives the config clock in the three master modes
   assign drive_clk = !done_r && (state_r != ST_IDLE) && (cap_r.mode == MODE_MASTER_SERIAL
      || cap_r.mode == MODE_SERIAL_FLASH || cap_r.mode == MODE_PARALLEL_FLASH);

   // Gated divider, runs only in parallel flash mode when downstream parts share the clock
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         bdiv_r <= 4'h0;
         bclk_r <= 1'h0;
      end else if (daisy_r && cap_r.mode == MODE_PARALLEL_FLASH && state_r == ST_EXT) begin
         bdiv_r <= (bdiv_r == DIV_LAST) ? 4'h0 : bdiv_r + 4'h1;
         bclk_r <= (bdiv_r == DIV_LAST) ? ~bclk_r : bclk_r;
      end else begin
         bdiv_r <= 4'h0;
         bclk_r <= 1'h0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_config_clock_pin <= 1'h0;
         o_config_clock_pin_oe <= 1'h0;
         o_flash_mosi <= 1'h0;
      end else begin
         o_config_clock_pin_oe <= drive_clk;
         // R12: parallel mode clock only for daisy chain
         o_config_clock_pin <= (cap_r.mode == MODE_PARALLEL_FLASH) ? bclk_r : sh_sclk;
         o_flash_mosi <= sh_mosi;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_user_pullup_en <= 1'h0;
         o_user_pins_hiz <= 1'h1;
         o_dual_pins_release <= 1'h0;
         o_done <= 1'h0;
      end else begin
         // R6: pull-ups held until done; R7: off when strap high
         o_user_pullup_en <= !done_r && !cap_r.pullup_disable_strap;
         o_user_pins_hiz <= !done_r;
         // R10: release only with done
         o_dual_pins_release <= done_r;
         o_done <= done_r;
      end
   end

   // ----------------------------------------
   // APB registers
   // ----------------------------------------
   // One wait state keeps read data and ready straight from flops
   assign acc = i_psel & i_penable;

   always_comb begin
      rd_data = '0;
      hit = 1'h1;
      case (i_paddr)
         REG_CTRL: rd_data[CTRL_DAISY_BIT] = daisy_r;
         REG_LEN: rd_data[LEN_W-1:0] = len_r;
         REG_STATUS: begin
            rd_data[ST_DONE_BIT] = done_r;
            rd_data[ST_ERR_BIT] = (state_r == ST_ERR);
            rd_data[ST_BUSY_BIT] = sh_busy;
            rd_data[ST_MODE_LSB +: 3] = cap_r.mode;
            rd_data[ST_VAR_LSB +: 3] = cap_r.flash_variant_straps;
            rd_data[ST_PUD_BIT] = cap_r.pullup_disable_strap;
            rd_data[ST_CLKIN_BIT] = config_clock_pin_s2;
         end
         REG_COUNT: rd_data[LEN_W-1:0] = cnt_r;
         default: hit = 1'h0;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pready <= 1'h0;
         o_prdata <= '0;
         o_pslverr <= 1'h0;
         daisy_r <= 1'h0;
         ext_done_r <= 1'h0;
         len_r <= '0;
      end else begin
         o_pready <= acc & ~o_pready;
         ext_done_r <= 1'h0;
         if (acc && !o_pready) begin
            o_prdata <= i_pwrite ? '0 : rd_data;
            o_pslverr <= ~hit;
         end
         if (acc && o_pready && i_pwrite) begin
            if (i_paddr == REG_CTRL) begin
               daisy_r <= i_pwdata[CTRL_DAISY_BIT];
               ext_done_r <= i_pwdata[CTRL_EXT_DONE_BIT];
            end
            if (i_paddr == REG_LEN) begin
               len_r <= i_pwdata[LEN_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   strap_capture_a: assert property ( // R1
      (state_r == ST_IDLE && init_rise) |=> (cap_r == $past(straps_s2) && state_r == ST_DECIDE))
      else $error("straps not caught on init rise");
   variant_ignored_a: assert property ( // R2
      (state_r == ST_DECIDE && cap_r.mode != MODE_SERIAL_FLASH)
      |=> (state_r != ST_CMD && state_r != ST_ERR && o_flash_cs_n))
      else $error("variant used outside serial flash mode");
   fast_read_a: assert property ( // R3
      (sh_start && state_r == ST_CMD && cap_r.flash_variant_straps == VAR_FAST)
      |-> (sh_tx == CMD_FAST_READ && dummy_n == DUMMY_FAST))
      else $error("fast read command or dummy wrong");
   plain_read_a: assert property ( // R4
      (state_r == ST_DUMMY) |-> (cap_r.flash_variant_straps != VAR_READ))
      else $error("dummy bytes sent for plain read");
   read_array_a: assert property ( // R5
      (sh_start && state_r == ST_CMD && cap_r.flash_variant_straps == VAR_ARRAY)
      |-> (sh_tx == CMD_READ_ARRAY && dummy_n == DUMMY_ARRAY))
      else $error("read array command or dummy wrong");
   pullup_hold_a: assert property ( // R6
      (!done_r && !cap_r.pullup_disable_strap) ##1 (!done_r && !cap_r.pullup_disable_strap)
      |=> o_user_pullup_en)
      else $error("pull-ups dropped before done");
   pullup_off_a: assert property ( // R7
      (cap_r.pullup_disable_strap && !done_r) |=> (!o_user_pullup_en && o_user_pins_hiz))
      else $error("pull-ups on while strap high");
   dual_release_a: assert property ( // R10
      o_dual_pins_release |-> (o_done && !o_user_pins_hiz))
      else $error("dual pins released before done");
   clock_drive_a: assert property ( // R11
      (shifting && !done_r) |=> o_config_clock_pin_oe)
      else $error("config clock not driven");
   daisy_only_a: assert property ( // R12
      (cap_r.mode == MODE_PARALLEL_FLASH && !daisy_r) [*3] |-> !o_config_clock_pin)
      else $error("parallel mode clock toggles without daisy chain");
   reserved_idle_a: assert property ( // R13
      (state_r == ST_ERR) |=> (o_flash_cs_n && !sh_busy && state_r == ST_ERR))
      else $error("flash accessed with reserved variant");
   zero_addr_a: assert property ( // R14
      (sh_start && state_r != ST_CMD) |-> (sh_tx == FILL_BYTE))
      else $error("address or fill byte not zero");
endmodule // cfl_loader

//--- cfl_flash_model.sv
// ----------------------------------------
// Serial flash partner, data changes on falling clock
// ----------------------------------------
module cfl_flash_model (
   // Reset and mode
   input wire logic i_rst,
   input wire logic i_raw,
   // Serial side
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   // Reply and captured header
   output logic o_miso,
   output logic [7:0] o_cmd,
   output logic [23:0] o_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   import cfl_pkg::*;
   logic [15:0] cnt;
   logic [15:0] hdr;
   logic sel;
   function automatic logic dbit(input logic [15:0] k);
      logic [7:0] p;
      p = 8'hC3 ^ (k[10:3] * 8'h1D);
      return p[3'h7 - k[2:0]];
   endfunction
   // Raw mode is a plain serial memory without select
   assign sel = i_raw | ~i_cs_n;
   always_comb begin
      case (o_cmd)
         8'h0B: hdr = 16'h28;
         8'hE8: hdr = 16'h40;
         default: hdr = 16'h20;
      endcase
      if (i_raw) hdr = 16'h0;
   end
   always @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 16'h0;
         o_cmd <= 8'h0;
         o_addr <= 24'h0;
      end else if (sel) begin
         cnt <= cnt + 16'h1;
         if (cnt < 16'h8) o_cmd <= {o_cmd[6:0], i_mosi};
         else if (cnt < 16'h20) o_addr <= {o_addr[22:0], i_mosi};
      end
   end
   // Deselected or in header: keeps toggling so a stale bit never passes
   always @(negedge i_sclk or posedge i_rst or posedge i_cs_n) begin
      if (i_rst) o_miso <= dbit(16'h0);
      else if (sel && cnt >= hdr) o_miso <= dbit(cnt - hdr);
      else o_miso <= ~o_miso;
   end
endmodule // cfl_flash_model

//--- cfl_loader_bench.sv
module cfl_loader_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cfl_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst, i_psel, i_penable, i_pwrite, i_init_n, raw, miso, config_clock_pin_wire;
   logic [AW-1:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   logic o_pready, o_pslverr, o_config_clock_pin, o_config_clock_pin_oe, o_flash_cs_n;
   logic o_flash_mosi, o_cfg_byte_valid, o_user_pullup_en, o_user_pins_hiz;
   logic o_dual_pins_release, o_done, cs_seen, clk_prev;
   logic [7:0] o_cfg_byte, f_cmd;
   logic [23:0] f_addr;
   cfl_straps_t i_straps;
   int n_errors = 0;
   int checks_done = 0;
   int clk_edges;
   logic [7:0] exp_q[$];
   always #5 i_clock = ~i_clock;
   // Undriven clock pin floats up on the board
   assign config_clock_pin_wire = o_config_clock_pin_oe ? o_config_clock_pin : 1'h1;
   cfl_loader cfl_loader_inst (.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_straps, .i_init_n,
      .i_config_clock_pin(config_clock_pin_wire), .o_config_clock_pin, .o_config_clock_pin_oe,
      .o_flash_cs_n, .o_flash_mosi, .i_flash_miso(miso), .o_cfg_byte, .o_cfg_byte_valid,
      .o_user_pullup_en, .o_user_pins_hiz, .o_dual_pins_release, .o_done);
   cfl_flash_model cfl_flash_model_inst (.i_rst, .i_raw(raw), .i_sclk(o_config_clock_pin),
      .i_cs_n(o_flash_cs_n), .i_mosi(o_flash_mosi), .o_miso(miso), .o_cmd(f_cmd),
      .o_addr(f_addr));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   function automatic logic [7:0] pat(input int k);
      return 8'hC3 ^ (8'(k) * 8'h1D);
   endfunction
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic fail(input string m);
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic check_bit(input logic g, input logic x);
      checks_done++;
      if (g !== x) fail($sformatf("flag %b expected %b", g, x));
   endtask
   task automatic check_byte(input logic [7:0] g, input logic [7:0] x);
      checks_done++;
      if (g !== x) fail($sformatf("byte %h expected %h", g, x));
   endtask
   task automatic check_word(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) fail($sformatf("word %h expected %h", g, x));
   endtask
   // Output watcher: counts clock toggles, select, and compares data bytes
   always @(posedge i_clock) begin
      if (i_rst === 1'b1) begin
         cs_seen <= 1'b0;
         clk_edges <= 0;
      end else begin
         if (o_flash_cs_n === 1'b0) cs_seen <= 1'b1;
         if (o_config_clock_pin !== clk_prev) clk_edges <= clk_edges + 1;
      end
      clk_prev <= o_config_clock_pin;
      if (o_cfg_byte_valid === 1'b1) begin
         if (exp_q.size() == 0) fail("unexpected data byte");
         else check_byte(o_cfg_byte, exp_q.pop_front());
      end
   end
   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20) begin
         fail("bus timeout");
         conclude();
      end
   endtask
   task automatic wait_done();
      int n;
      for (n = 0; n < 8000 && o_done !== 1'b1; n++) @(posedge i_clock);
      if (n >= 8000) begin
         fail("done timeout");
         conclude();
      end
   endtask
   task automatic run(input logic [2:0] md, input logic [2:0] vs, input logic pud, input int len);
      logic [31:0] q;
      logic e;
      logic ok_vs;
      ok_vs = (vs == 3'h7) || (vs == 3'h5) || (vs == 3'h6);
      i_rst <= 1'b1;
      i_init_n <= 1'b0;
      raw <= (md == MODE_MASTER_SERIAL);
      // pull-up strap fixed; other straps junk until start
      i_straps <= {pud, ~md, ~vs};
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      apb(1'b1, REG_LEN, 32'(len), q, e);
      i_straps <= {pud, md, vs};
      repeat (2) @(posedge i_clock);
      i_init_n <= 1'b1;
      repeat (8) @(posedge i_clock);
      check_bit(o_user_pullup_en, ~pud);
      check_bit(o_user_pins_hiz, 1'b1);
      check_bit(o_dual_pins_release, 1'b0);
      // Late strap changes must not reach the captured copy
      i_straps <= {pud, ~md, ~vs};
      if (md == MODE_PARALLEL_FLASH) begin
         check_bit(o_config_clock_pin_oe, 1'b1);
         repeat (100) @(posedge i_clock);
         check_word(32'(clk_edges), 32'h0);
         apb(1'b1, REG_CTRL, 32'h1, q, e);
         repeat (100) @(posedge i_clock);
         check_bit(clk_edges > 0, 1'b1);
         apb(1'b1, REG_CTRL, 32'h2, q, e);
      end else if (md == MODE_SERIAL_FLASH && !ok_vs) begin
         for (int n = 0; n < 40 && q[ST_ERR_BIT] !== 1'b1; n++)
            apb(1'b0, REG_STATUS, 32'h0, q, e);
         check_bit(q[ST_ERR_BIT], 1'b1);
         check_bit(o_done, 1'b0);
      end else begin
         for (int k = 0; k < len; k++) exp_q.push_back(pat(k));
         wait_done();
         check_word(32'(exp_q.size()), 32'h0);
         check_bit(clk_edges > 0, 1'b1);
         if (md == MODE_SERIAL_FLASH) begin
            check_byte(f_cmd, vs == 3'h7 ? 8'h0B : vs == 3'h5 ? 8'h03 : 8'hE8);
            check_word({8'h0, f_addr}, 32'h0);
         end
      end
      check_bit(cs_seen, md == MODE_SERIAL_FLASH && ok_vs);
      if (md != MODE_SERIAL_FLASH || ok_vs) begin
         wait_done();
         check_bit(o_dual_pins_release, 1'b1);
         check_bit(o_user_pullup_en, 1'b0);
      end
      apb(1'b0, REG_STATUS, 32'h0, q, e);
      check_byte({2'h0, q[ST_VAR_LSB+:3], q[ST_MODE_LSB+:3]}, {2'h0, vs, md});
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      i_rst <= 1'b1;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = '0;
      i_pwdata = 32'h0;
      i_init_n = 1'b0;
      raw = 1'b0;
      i_straps = '0;
      void'($urandom(73));
      @(posedge i_clock);
      run(MODE_SERIAL_FLASH, 3'h7, 1'b0, 1 + $urandom % 3);
      run(MODE_SERIAL_FLASH, 3'h5, 1'b1, 1 + $urandom % 3);
      run(MODE_SERIAL_FLASH, 3'h6, 1'b0, 2);
      run(MODE_SERIAL_FLASH, 3'($urandom % 5), 1'b0, 2);
      run(MODE_MASTER_SERIAL, 3'($urandom), 1'b1, 2);
      run(MODE_PARALLEL_FLASH, 3'h7, 1'b0, 1);
      apb(1'b0, 12'h010, 32'h0, q, e);
      check_bit(e, 1'b1);
      check_word(q, 32'h0);
      conclude();
   end
endmodule // cfl_loader_bench
